// >>> shared/pio_map.svh
`ifndef PIO_MAP_SVH
`define PIO_MAP_SVH

// bank geometry: nine ports, each on a 16-line slot
`define PIO_NPORTS 9
`define PIO_LINES 144
// implemented lines, port 8 in the top slot, port 0 in the bottom one
`define PIO_LINE_MASK 144'h00ff_00ff_00ff_ffff_00ff_bfff_ffff_ffff_ffff
// ports with an output driver (port 5 is input only)
`define PIO_OUT_CAP 9'h1df
// ports whose drivers can be switched to open drain
`define PIO_OD_CAP 9'h1dc
// port that carries the segment address lines
`define PIO_SEG_PORT 4
// segment address lines taken away while a CAN controller is in use
`define PIO_SEG_CAN_BLOCK 16'h00f0

// per-port register index, byte address = port*0x20 + index*4
`define REG_DATA 3'h0
`define REG_SET 3'h1
`define REG_CLR 3'h2
`define REG_TGL 3'h3
`define REG_DIR 3'h4
`define REG_ODS 3'h5
`define REG_ALT 3'h6
`define REG_PIN 3'h7
// global registers live in slot 0x10 (byte address 0x200)
`define GLOBAL_SEL 5'h10
`define REG_THR 3'h0
`define REG_XTHR 3'h1
`define REG_STAT 3'h2

// reset values
`define LATCH_RST 16'h0000
`define DIR_RST 16'h0000
`define THR_RST 9'h000

// timing: one state time is two cycles of the cpu clock
`define CLK_PERIOD_NS 100
`define STATE_TIME_NS 200
`define STATE_CYCLES ((`STATE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// >>> shared/pio_pkg.sv
package pio_pkg;

   typedef enum logic [0:0] {
      RD_IDLE = 1'b0,
      RD_RESP = 1'b1
   } rd_state_t;

   typedef struct packed {
      logic [15:0] out_latch;
      logic [15:0] dir;
      logic [15:0] ods;
      logic [15:0] alt;
      logic [15:0] in_latch;
      logic [15:0] pin_out;
      logic [15:0] pin_oe;
   } port_state_t;

   typedef struct packed {
      logic [143:0] meta;
      logic [143:0] sync;
   } sync_state_t;

   typedef struct packed {
      logic [7:0] aw_addr;
      logic aw_bad;
      logic aw_held;
      logic w_held;
      logic [15:0] wdata;
      logic [1:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      rd_state_t rd;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [3:0] div;
      logic tick;
      logic [8:0] thr;
      logic [8:0] xthr;
   } top_state_t;

endpackage

// >>> design/pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // raw pad levels and their synchronised copy
   input wire logic [143:0] pin_raw,
   output logic [143:0] pin_sync
);
   pio_pkg::sync_state_t s;
   pio_pkg::sync_state_t n;

   // the first stage feeds only the second stage
   always_comb begin
      n = s;
      n.meta = pin_raw;
      n.sync = s.meta;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign pin_sync = s.sync;
endmodule

// >>> design/port_ctl.sv
`timescale 1ns/1ps
`include "pio_map.svh"
module port_ctl #(
   parameter logic [15:0] MASK = 16'hffff,
   parameter logic HAS_OUT = 1'b1,
   parameter logic HAS_OD = 1'b1
) (
   // clock, reset, state-time strobe
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tick,
   // register write
   input wire logic wr,
   input wire logic [2:0] wreg,
   input wire logic [15:0] wdata,
   input wire logic [15:0] wmask,
   // register read
   input wire logic [2:0] rreg,
   output logic [15:0] rd_val,
   // pads and peripherals
   input wire logic [15:0] pin_in,
   input wire logic [15:0] alt_out,
   input wire logic [15:0] alt_block,
   output logic [15:0] in_q,
   output logic [15:0] pin_out,
   output logic [15:0] pin_oe
);
   pio_pkg::port_state_t s;
   pio_pkg::port_state_t n;
   logic [15:0] rv;
   logic [15:0] val;
   logic [15:0] use_alt;

   // per-line read value: latch for outputs, sampled pin for inputs
   assign rv = (s.dir & s.out_latch) | (~s.dir & s.in_latch);

   always_comb begin
      n = s;
      if (tick) begin
         n.in_latch = pin_in & MASK;
      end
      if (wr) begin
         case (wreg)
            `REG_DATA: n.out_latch = (s.out_latch & ~wmask) | (wdata & wmask);
            // read-modify-write: operand follows direction per line
            `REG_SET: n.out_latch = (s.out_latch & ~wmask) | ((rv | wdata) & wmask);
            `REG_CLR: n.out_latch = (s.out_latch & ~wmask) | ((rv & ~wdata) & wmask);
            `REG_TGL: n.out_latch = (s.out_latch & ~wmask) | ((rv ^ wdata) & wmask);
            `REG_DIR: n.dir = HAS_OUT ? ((s.dir & ~wmask) | (wdata & wmask)) : `DIR_RST;
            `REG_ODS: n.ods = HAS_OD ? ((s.ods & ~wmask) | (wdata & wmask)) : `LATCH_RST;
            `REG_ALT: n.alt = (s.alt & ~wmask) | (wdata & wmask);
            default: n.out_latch = s.out_latch;
         endcase
      end
      n.out_latch = n.out_latch & MASK;
      n.dir = n.dir & MASK;
      n.ods = n.ods & MASK;
      n.alt = n.alt & MASK;
      // drive from the alternate function or the output latch
      use_alt = n.alt & ~alt_block;
      val = (use_alt & alt_out) | (~use_alt & n.out_latch);
      // open drain only pulls low; push-pull drives both levels
      n.pin_oe = n.dir & ~(n.ods & val);
      n.pin_out = val & ~n.ods;
   end

   always_comb begin
      case (rreg)
         `REG_DIR: rd_val = s.dir;
         `REG_ODS: rd_val = s.ods;
         `REG_ALT: rd_val = s.alt;
         `REG_PIN: rd_val = s.in_latch;
         default: rd_val = rv;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign in_q = s.in_latch;
   assign pin_out = s.pin_out;
   assign pin_oe = s.pin_oe;
endmodule

// >>> design/pio_bank.sv
`timescale 1ns/1ps
`include "pio_map.svh"
// Behaviour
// - port 0 as independent low/high bytes
// - port 1 as independent low/high bytes
// - port 2 has sixteen bidirectional lines
// - port 3 fifteen lines, bit fourteen absent
// - port 4 has eight bidirectional lines
// - port 5 sixteen lines, input only
// - ports 6, 7, 8 eight lines each
// - per-bit open drain on ports 2-4,6-8
// - per-port TTL/CMOS threshold select bits
// - pins sampled every state time, any direction
// - input line: write latch only, read pin
// - input line: RMW uses pin, stores latch
// - output line: write drives pin via latch
// - output line: read returns output latch
// - output line: RMW uses latch, drives pin
// - every line has an alternate function path
// - CAN in use: four segment lines only
module pio_bank (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [11:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   // axi4-lite write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // axi4-lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read address
   input wire logic [11:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   // axi4-lite read data
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // pads, one 16-line slot per port
   input wire logic [143:0] pin_in,
   output logic [143:0] pin_out,
   output logic [143:0] pin_oe,
   // alternate function paths
   input wire logic [143:0] alt_out,
   output logic [143:0] alt_in,
   input wire logic [1:0] can_in_use,
   // pad threshold selects, one bit per port
   output logic [8:0] cmos_sel,
   output logic [8:0] ext_cmos_sel
);
   localparam logic [143:0] LINE_MASK = `PIO_LINE_MASK;
   localparam logic [8:0] OUT_CAP = `PIO_OUT_CAP;
   localparam logic [8:0] OD_CAP = `PIO_OD_CAP;
   localparam logic [3:0] DIV_LAST = 4'(`STATE_CYCLES - 1);
   localparam logic [4:0] NPORTS = 5'(`PIO_NPORTS);

   pio_pkg::top_state_t s;
   pio_pkg::top_state_t n;

   logic [143:0] pin_s;
   logic [15:0] prd [9];
   logic wr_go;
   logic [4:0] wr_port;
   logic [2:0] wr_reg;
   logic [15:0] wmask;
   logic w_ok;
   logic [4:0] rd_port;
   logic [2:0] rd_reg;
   logic [15:0] rd_mux;
   logic rd_ok;
   logic can_any;

   // pads come from outside the clock domain
   pin_sync u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_raw(pin_in),
      .pin_sync(pin_s)
   );

   // a write completes once both address and data are held
   assign wr_go = s.aw_held & s.w_held & ~s.bvalid;
   assign wr_port = s.aw_addr[7:3];
   assign wr_reg = s.aw_addr[2:0];
   // byte lanes let each half of a 16-bit port be written alone
   assign wmask = {{8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
   assign can_any = |can_in_use;

   // write decode; writes to the status word are taken and ignored
   always_comb begin
      w_ok = 1'b0;
      if (!s.aw_bad) begin
         if (wr_port < NPORTS) begin
            w_ok = 1'b1;
         end else if (wr_port == `GLOBAL_SEL && wr_reg <= `REG_STAT) begin
            w_ok = 1'b1;
         end
      end
   end

   // one controller per port; geometry fixed by the mask tables
   for (genvar i = 0; i < `PIO_NPORTS; i++) begin : g_port
      logic [15:0] blk;
      // CAN owns the upper segment lines of the address port
      assign blk = (i == `PIO_SEG_PORT && can_any) ? `PIO_SEG_CAN_BLOCK : 16'h0000;
      port_ctl #(
         .MASK(LINE_MASK[i*16 +: 16]),
         .HAS_OUT(OUT_CAP[i]),
         .HAS_OD(OD_CAP[i])
      ) u_port (
         .aclk(aclk),
         .aresetn(aresetn),
         .tick(s.tick),
         .wr(wr_go && w_ok && wr_port == 5'(i)),
         .wreg(wr_reg),
         .wdata(s.wdata),
         .wmask(wmask),
         .rreg(rd_reg),
         .rd_val(prd[i]),
         .pin_in(pin_s[i*16 +: 16]),
         .alt_out(alt_out[i*16 +: 16]),
         .alt_block(blk),
         .in_q(alt_in[i*16 +: 16]),
         .pin_out(pin_out[i*16 +: 16]),
         .pin_oe(pin_oe[i*16 +: 16])
      );
   end

   // read decode, sampled in the address handshake cycle
   assign rd_port = araddr[9:5];
   assign rd_reg = araddr[4:2];

   always_comb begin
      rd_ok = 1'b0;
      rd_mux = 16'h0000;
      if (araddr[11:10] == 2'b00) begin
         if (rd_port < NPORTS) begin
            rd_ok = 1'b1;
            rd_mux = prd[rd_port[3:0]];
         end else if (rd_port == `GLOBAL_SEL) begin
            case (rd_reg)
               `REG_THR: begin
                  rd_ok = 1'b1;
                  rd_mux = {7'h00, s.thr};
               end
               `REG_XTHR: begin
                  rd_ok = 1'b1;
                  rd_mux = {7'h00, s.xthr};
               end
               `REG_STAT: begin
                  rd_ok = 1'b1;
                  rd_mux = {14'h0000, can_in_use};
               end
               default: begin
                  rd_ok = 1'b0;
               end
            endcase
         end
      end
   end

   // bus slave, state-time divider and global registers
   always_comb begin
      n = s;
      n.tick = 1'b0;
      // state-time strobe paces the input latches
      if (s.div == DIV_LAST) begin
         n.div = 4'h0;
         n.tick = 1'b1;
      end else begin
         n.div = s.div + 4'h1;
      end
      // address and data may arrive in either order
      if (s.awready && awvalid) begin
         n.aw_held = 1'b1;
         n.aw_addr = awaddr[9:2];
         n.aw_bad = awaddr[11:10] != 2'b00;
      end
      if (s.wready && wvalid) begin
         n.w_held = 1'b1;
         n.wdata = wdata[15:0];
         n.wstrb = wstrb[1:0];
      end
      if (wr_go) begin
         n.aw_held = 1'b0;
         n.w_held = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = w_ok ? `RESP_OKAY : `RESP_SLVERR;
         if (w_ok && wr_port == `GLOBAL_SEL) begin
            if (wr_reg == `REG_THR) begin
               if (s.wstrb[0]) n.thr[7:0] = s.wdata[7:0];
               if (s.wstrb[1]) n.thr[8] = s.wdata[8];
            end
            if (wr_reg == `REG_XTHR) begin
               if (s.wstrb[0]) n.xthr[7:0] = s.wdata[7:0];
               if (s.wstrb[1]) n.xthr[8] = s.wdata[8];
            end
         end
      end
      if (s.bvalid && bready) begin
         n.bvalid = 1'b0;
      end
      // read: one cycle to the answer, held until rready
      unique case (s.rd)
         pio_pkg::RD_IDLE: begin
            if (s.arready && arvalid) begin
               n.rd = pio_pkg::RD_RESP;
               n.rdata = {16'h0000, rd_mux};
               n.rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
         end
         pio_pkg::RD_RESP: begin
            if (rready) begin
               n.rd = pio_pkg::RD_IDLE;
               n.rdata = 32'h0000_0000;
            end
         end
      endcase
      // readies drop while a transfer is pending, so one at a time
      n.awready = ~n.aw_held & ~n.bvalid;
      n.wready = ~n.w_held & ~n.bvalid;
      n.arready = n.rd == pio_pkg::RD_IDLE;
      n.rvalid = n.rd == pio_pkg::RD_RESP;
   end

   // readies come up one cycle after reset release
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // every output straight from a state flop
   assign awready = s.awready;
   assign wready = s.wready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.arready;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;
   assign cmos_sel = s.thr;
   assign ext_cmos_sel = s.xthr;
endmodule

// >>> test/pio_pads.sv
`timescale 1ns/1ps
module pio_pads (
   // design side of each pad
   input wire logic [143:0] pin_out,
   input wire logic [143:0] pin_oe,
   // board drivers, worked by the bench
   input wire logic [143:0] ext_val,
   input wire logic [143:0] ext_en,
   // resolved pad levels
   output logic [143:0] pin_in
);
   // board pull-ups: a released line reads high, so open drain idles at 1
   always_comb begin
      for (int i = 0; i < 144; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
      end
   end
endmodule

// >>> test/pio_bank_checker.sv
`timescale 1ns/1ps
`include "pio_map.svh"
module pio_bank_checker (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus handshakes
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   // pads and selects
   input wire logic [143:0] pin_in,
   input wire logic [143:0] pin_oe,
   input wire logic [143:0] alt_in,
   input wire logic [8:0] cmos_sel
);
   localparam logic [143:0] MASK = `PIO_LINE_MASK;
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // absent or input-only lines never drive
   a_input_only: assert property (pin_oe[95:80] == 16'h0000)
      else $error("input-only port drives a pad");
   a_gap_line: assert property (!pin_oe[62])
      else $error("absent line drives a pad");
   a_port4_width: assert property (pin_oe[79:72] == 8'h00)
      else $error("port 4 upper slot driven");
   a_narrow_ports: assert property (
      (pin_oe[111:104] | pin_oe[127:120] | pin_oe[143:136]) == 8'h00)
      else $error("narrow port upper slot driven");
   // reset must release every pad, so no disable here
   a_reset_inputs: assert property (disable iff (1'b0) !aresetn |=> pin_oe == '0)
      else $error("pad driven after reset");
   // steady pads reach the input latch within the sync and state-time delay
   a_pin_sample: assert property (
      $stable(pin_in) [*7] |-> (alt_in & MASK) == (pin_in & MASK))
      else $error("input latch misses the pad level");
   a_thr_write: assert property ($changed(cmos_sel) |-> $rose(bvalid))
      else $error("threshold select moved without a write");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
      else $error("write answer late");
endmodule
bind pio_bank pio_bank_checker props (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
   .bvalid, .arvalid, .arready, .rvalid, .pin_in, .pin_oe, .alt_in, .cmos_sel);

// >>> test/parallel_io_port_bank_test.sv
`timescale 1ns/1ps
module parallel_io_port_bank_test;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = '0;
   logic [143:0] ext_val = '0, ext_en = '0, alt_out = '0;
   logic [1:0] can_in_use = '0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [143:0] pin_in, pin_out, pin_oe, alt_in;
   logic [8:0] cmos_sel, ext_cmos_sel;
   int err_count = 0, cmp_count = 0, cycles = 0;
   logic [15:0] dir_w[9] = '{16'hffff, 16'hffff, 16'hffff, 16'hbfff, 16'h00ff, 16'h0000,
      16'h00ff, 16'h00ff, 16'h00ff};

   always #50 aclk = ~aclk;

   pio_bank dut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .pin_in, .pin_out, .pin_oe, .alt_out, .alt_in,
      .can_in_use, .cmos_sel, .ext_cmos_sel);
   pio_pads pads (.pin_out, .pin_oe, .ext_val, .ext_en, .pin_in);

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // a hang ends in the same report
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 4000) begin
         err_count++;
         finish_test();
      end
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // address and data offered together, each dropped when taken
   task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s = 4'hf,
      input logic [1:0] er = 2'b00);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {16'h0000, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      fork
         begin
            do @(posedge aclk); while (!awready);
            awvalid <= 1'b0;
         end
         begin
            do @(posedge aclk); while (!wready);
            wvalid <= 1'b0;
         end
      join
      while (!bvalid) @(posedge aclk);
      bready <= 1'b0;
      cmp(bresp, er);
   endtask

   task automatic rd(input logic [11:0] a, input logic [15:0] exp, input logic [1:0] er = 2'b00);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge aclk);
      rready <= 1'b0;
      cmp(rresp, er);
      if (er == 2'b00) cmp(rdata, {16'h0000, exp});
   endtask

   task automatic t_reset();
      cmp(32'(|pin_oe), 32'h0000_0000);
      for (int p = 0; p < 9; p++) rd(12'(p * 32 + 16), 16'h0000);
   endtask

   task automatic t_bytes();
      wr(12'h010, 16'hffff);
      wr(12'h000, 16'h1111);
      wr(12'h000, 16'habcd, 4'h1);
      wr(12'h000, 16'h5500, 4'h2);
      rd(12'h000, 16'h55cd);
      wr(12'h030, 16'hffff);
      wr(12'h020, 16'habcd, 4'h2);
      cmp(pin_out[31:16], 16'hab00);
   endtask

   // port 2 driven from the board, then turned round
   task automatic t_rmw();
      ext_val[47:32] <= 16'ha5c3;
      ext_en[47:32] <= 16'hffff;
      wr(12'h040, 16'h1234);
      idle(8);
      cmp(pin_oe[47:32], 16'h0000);
      cmp(alt_in[47:32], 16'ha5c3);
      rd(12'h040, 16'ha5c3);
      wr(12'h044, 16'h000f);
      ext_en[47:32] <= 16'h0000;
      wr(12'h050, 16'hffff);
      cmp(pin_out[47:32], 16'ha5cf);
      wr(12'h04c, 16'h00ff);
      cmp(pin_out[47:32], 16'ha530);
      wr(12'h048, 16'h0030);
      cmp(pin_out[47:32], 16'ha500);
      idle(8);
      rd(12'h05c, 16'ha500);
   endtask

   // released open-drain line pulled low from outside
   task automatic t_drain();
      wr(12'h070, 16'hffff);
      wr(12'h074, 16'h0001);
      wr(12'h060, 16'h0003);
      cmp({pin_oe[49:48], pin_out[49:48]}, 4'b1010);
      ext_en[48] <= 1'b1;
      idle(8);
      rd(12'h060, 16'h0003);
      rd(12'h07c, 16'h0002);
      ext_en[48] <= 1'b0;
      wr(12'h014, 16'hffff);
      rd(12'h014, 16'h0000);
   endtask

   task automatic t_widths();
      for (int p = 2; p < 9; p++) begin
         wr(12'(p * 32 + 16), 16'hffff);
         rd(12'(p * 32 + 16), dir_w[p]);
      end
   endtask

   task automatic t_alt();
      alt_out[79:64] <= 16'h00f0;
      alt_out[32] <= 1'b1;
      wr(12'h058, 16'h0001);
      cmp(pin_out[32], 1'b1);
      wr(12'h098, 16'h00f0);
      idle(2);
      cmp(pin_out[71:64], 8'hf0);
      for (int c = 1; c < 4; c++) begin
         can_in_use <= 2'(c);
         idle(3);
         cmp(pin_out[71:64], 8'h00);
      end
      can_in_use <= 2'b00;
   endtask

   task automatic t_regs();
      wr(12'h200, 16'h01ff);
      wr(12'h204, 16'h00a5);
      cmp({cmos_sel, ext_cmos_sel}, 18'h3_fea5);
      rd(12'h200, 16'h01ff);
      wr(12'h200, 16'h0000);
      cmp(cmos_sel, 9'h000);
      // status word is read-only: the write is answered and dropped
      wr(12'h208, 16'hffff);
      rd(12'h208, 16'h0000);
      wr(12'h300, 16'hffff, 4'hf, 2'b10);
      rd(12'h3fc, 16'h0000, 2'b10);
   endtask

   // main sequence
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_bytes();
      t_rmw();
      t_drain();
      t_widths();
      t_alt();
      t_regs();
      finish_test();
   end
endmodule
